// *** lss_link_startup_sequencer.sv ***
// host-side link startup sequencer: management requests and trigger exchange
// How it works
// - after reset both physical layers self-initialise and rest in hibernate; we wait for ours.
// - issue reset request, await confirm, enable request, await confirm, restore attributes, startup.
// - the whole exchange runs in pulse width gear one.
// - phase 0 repeats trigger zero on all lanes and discovers lanes from received trigger zero.
// - phase 0b sends exactly two trigger one symbols and ignores received data.
// - phase 1 repeats trigger one until it arrives on every lane in the lane mask, then goes to phase 2.
// - phase 2 sends exactly two trigger one symbols, ignores received data, then goes to phase 3.
// - phase 3 repeats trigger two and watches only receive lane 0 for trigger two.
// - phase 4 sends exactly two trigger two symbols on all lanes, ignores data, then phase 5.
// - phase 5 sends own capabilities, starts a media converter transfer, and takes the lower of own and peer's, lane count also capped at the lanes found.
`include "lss_defs.svh"

module lss_link_startup_sequencer
	import lss_pkg::*;
#(
	parameter int NUM_LANES = 2
) (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst,
	// control from host logic
	input  wire logic                          start,
	input  wire lss_caps_t                     own_caps,
	// own physical layer status pin
	input  wire logic                          phy_hibernate,
	// management confirms from the device
	input  wire logic                          mgmt_reset_cnf,
	input  wire logic                          mgmt_enable_cnf,
	input  wire logic                          link_startup_cnf,
	// management requests to the device
	output lss_mgmt_req_t                      mgmt_req,
	// link lanes
	input  wire lss_lane_t [NUM_LANES-1:0]     rx_lanes,
	output lss_lane_t      [NUM_LANES-1:0]     tx_lanes,
	// status
	output logic                               mc_cap_start,
	output logic                               busy,
	output logic                               linkup,
	output logic           [`LSS_PWR_W-1:0]    power_mode,
	output logic           [`LSS_GEAR_W-1:0]   gear,
	output logic           [NUM_LANES-1:0]     lane_mask,
	output lss_caps_t                          peer_caps,
	output lss_caps_t                          agreed_caps
);

	if (NUM_LANES < 1 || NUM_LANES > `LSS_MAX_LANES) begin : g_bad_lanes
		$error("lss_link_startup_sequencer: NUM_LANES out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic [3:0] lss_min4(input logic [3:0] a, input logic [3:0] b);
		lss_min4 = (a < b) ? a : b;
	endfunction : lss_min4

	function automatic logic [3:0] lss_count(input logic [NUM_LANES-1:0] m);
		logic [3:0] c;
		c = 4'h0;
		for (int i = 0; i < NUM_LANES; i++) begin
			c = c + {3'h0, m[i]};
		end
		lss_count = c;
	endfunction : lss_count

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	localparam int SW = NUM_LANES * $bits(lss_lane_t) + 4;

	logic [SW-1:0]                   sync_out;
	lss_lane_t [NUM_LANES-1:0]       rx_s;
	logic                            hib_s, rst_cnf_s, en_cnf_s, ls_cnf_s;

	lss_sync #(.W(SW)) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({rx_lanes, phy_hibernate, mgmt_reset_cnf, mgmt_enable_cnf, link_startup_cnf}),
		.q   (sync_out)
	);

	assign {rx_s, hib_s, rst_cnf_s, en_cnf_s, ls_cnf_s} = sync_out;

	////////////////////////////////////////////////////////////////////////////
	// receive decode

	logic [NUM_LANES-1:0] rx_trg0, rx_trg1;

	always_comb begin
		for (int i = 0; i < NUM_LANES; i++) begin
			rx_trg0[i] = (rx_s[i].sym == LSS_SYM_TRG0);
			rx_trg1[i] = (rx_s[i].sym == LSS_SYM_TRG1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	lss_state_t                     state_q, state_d;
	logic [`LSS_CNT_W-1:0]          cnt_q, cnt_d;
	lss_mgmt_req_t                  req_q, req_d;
	lss_lane_t [NUM_LANES-1:0]      tx_q, tx_d;
	logic                           mc_q, mc_d;
	logic                           linkup_q, linkup_d;
	logic [`LSS_PWR_W-1:0]          pwr_q, pwr_d;
	logic [NUM_LANES-1:0]           mask_q, mask_d;
	lss_caps_t                      peer_q, peer_d;
	lss_caps_t                      agree_q, agree_d;
	lss_lane_t                      tx_sym;

	always_comb begin
		state_d  = state_q;
		cnt_d    = cnt_q;
		req_d    = '0;
		mc_d     = 1'b0;
		linkup_d = linkup_q;
		pwr_d    = pwr_q;
		mask_d   = mask_q;
		peer_d   = peer_q;
		agree_d  = agree_q;
		tx_sym   = '{sym: LSS_SYM_IDLE, data: '0};

		unique case (state_q)
			LSS_ST_IDLE: begin
				if (start && hib_s) begin
					state_d         = LSS_ST_RST;
					req_d.reset_req = 1'b1;
				end
			end
			LSS_ST_RST: begin
				if (rst_cnf_s) begin
					state_d          = LSS_ST_EN;
					req_d.enable_req = 1'b1;
				end
			end
			LSS_ST_EN: begin
				if (en_cnf_s) begin
					state_d            = LSS_ST_ATTR;
					req_d.attr_restore = 1'b1;
					linkup_d           = 1'b0;
					pwr_d              = `LSS_PWR_NONE;
					mask_d             = '0;
				end
			end
			LSS_ST_ATTR: begin
				state_d           = LSS_ST_P0;
				req_d.startup_req = 1'b1;
			end
			LSS_ST_P0: begin
				tx_sym.sym = LSS_SYM_TRG0;
				// device may already be sending; either start is fine
				if (|rx_trg0) begin
					mask_d  = rx_trg0;
					state_d = LSS_ST_P0B;
					cnt_d   = '0;
				end
			end
			LSS_ST_P0B, LSS_ST_P2, LSS_ST_P4: begin
				tx_sym.sym = (state_q == LSS_ST_P4) ? LSS_SYM_TRG2 : LSS_SYM_TRG1;
				cnt_d      = cnt_q + 2'h1;
				if (cnt_q == `LSS_EXTRA_SYMS - 2'h1) begin
					cnt_d   = '0;
					unique case (state_q)
						LSS_ST_P0B: state_d = LSS_ST_P1;
						LSS_ST_P2:  state_d = LSS_ST_P3;
						default:    state_d = LSS_ST_P5;
					endcase
					if (state_q == LSS_ST_P4) begin
						mc_d = 1'b1;
					end
				end
			end
			LSS_ST_P1: begin
				tx_sym.sym = LSS_SYM_TRG1;
				if ((rx_trg1 & mask_q) == mask_q) begin
					state_d = LSS_ST_P2;
				end
			end
			LSS_ST_P3: begin
				tx_sym.sym = LSS_SYM_TRG2;
				if (rx_s[0].sym == LSS_SYM_TRG2) begin
					state_d = LSS_ST_P4;
				end
			end
			LSS_ST_P5: begin
				tx_sym.sym  = LSS_SYM_CAP;
				tx_sym.data = own_caps;
				if (rx_s[0].sym == LSS_SYM_CAP) begin
					peer_d           = rx_s[0].data;
					agree_d.max_gear = lss_min4(own_caps.max_gear, rx_s[0].data.max_gear);
					agree_d.lane_cnt = lss_min4(lss_min4(own_caps.lane_cnt,
						rx_s[0].data.lane_cnt), lss_count(mask_q));
					state_d = LSS_ST_LSWAIT;
				end
			end
			LSS_ST_LSWAIT: begin
				tx_sym.sym  = LSS_SYM_CAP;
				tx_sym.data = own_caps;
				if (ls_cnf_s) begin
					state_d  = LSS_ST_LINKUP;
					linkup_d = 1'b1;
					pwr_d    = `LSS_PWR_SLOW_AUTO;
				end
			end
			LSS_ST_LINKUP: begin
			end
			default: begin
				state_d = LSS_ST_IDLE;
			end
		endcase

		// a fresh start reruns the whole sequence from the reset request
		if (start && hib_s && state_q != LSS_ST_IDLE) begin
			state_d         = LSS_ST_RST;
			req_d           = '0;
			req_d.reset_req = 1'b1;
			mc_d            = 1'b0;
			linkup_d        = 1'b0;
			pwr_d           = `LSS_PWR_NONE;
			tx_sym          = '{sym: LSS_SYM_IDLE, data: '0};
		end

		for (int i = 0; i < NUM_LANES; i++) begin
			tx_d[i] = tx_sym;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q  <= LSS_ST_IDLE;
			cnt_q    <= '0;
			req_q    <= '0;
			tx_q     <= '0;
			mc_q     <= 1'b0;
			linkup_q <= 1'b0;
			pwr_q    <= `LSS_PWR_NONE;
			mask_q   <= '0;
			peer_q   <= '0;
			agree_q  <= '0;
		end else begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			req_q    <= req_d;
			tx_q     <= tx_d;
			mc_q     <= mc_d;
			linkup_q <= linkup_d;
			pwr_q    <= pwr_d;
			mask_q   <= mask_d;
			peer_q   <= peer_d;
			agree_q  <= agree_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	logic busy_q, busy_d;

	always_comb begin
		busy_d = (state_d != LSS_ST_IDLE) && (state_d != LSS_ST_LINKUP);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= busy_d;
		end
	end

	// gear stays at pulse width gear one for the whole exchange
	logic [`LSS_GEAR_W-1:0] gear_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			gear_q <= `LSS_GEAR_PULSE_WIDTH_GEAR_ONE;
		end else begin
			gear_q <= `LSS_GEAR_PULSE_WIDTH_GEAR_ONE;
		end
	end

	assign mgmt_req     = req_q;
	assign tx_lanes     = tx_q;
	assign mc_cap_start = mc_q;
	assign busy         = busy_q;
	assign linkup       = linkup_q;
	assign power_mode   = pwr_q;
	assign gear         = gear_q;
	assign lane_mask    = mask_q;
	assign peer_caps    = peer_q;
	assign agreed_caps  = agree_q;

endmodule : lss_link_startup_sequencer

// *** lss_defs.svh ***
// constants of the link startup sequencer
`ifndef LSS_DEFS_SVH
`define LSS_DEFS_SVH

`define LSS_SYNC_STAGES   3
`define LSS_EXTRA_SYMS    2'h2
`define LSS_CNT_W         2
`define LSS_GEAR_W        4
`define LSS_GEAR_PULSE_WIDTH_GEAR_ONE   4'h1
`define LSS_PWR_W         3
`define LSS_PWR_NONE      3'h0
`define LSS_PWR_SLOW_AUTO 3'h5
`define LSS_MAX_LANES     4

`endif

// *** lss_pkg.sv ***
// types shared by the link startup sequencer
package lss_pkg;

	typedef enum logic [2:0] {
		LSS_SYM_IDLE = 3'h0,
		LSS_SYM_TRG0 = 3'h1,
		LSS_SYM_TRG1 = 3'h2,
		LSS_SYM_TRG2 = 3'h3,
		LSS_SYM_CAP  = 3'h4
	} lss_sym_t;

	typedef struct packed {
		logic [3:0] max_gear;
		logic [3:0] lane_cnt;
	} lss_caps_t;

	typedef struct packed {
		lss_sym_t  sym;
		lss_caps_t data;
	} lss_lane_t;

	typedef struct packed {
		logic reset_req;
		logic enable_req;
		logic attr_restore;
		logic startup_req;
	} lss_mgmt_req_t;

	typedef enum logic [3:0] {
		LSS_ST_IDLE   = 4'h0,
		LSS_ST_RST    = 4'h1,
		LSS_ST_EN     = 4'h2,
		LSS_ST_ATTR   = 4'h3,
		LSS_ST_P0     = 4'h4,
		LSS_ST_P0B    = 4'h5,
		LSS_ST_P1     = 4'h6,
		LSS_ST_P2     = 4'h7,
		LSS_ST_P3     = 4'h8,
		LSS_ST_P4     = 4'h9,
		LSS_ST_P5     = 4'ha,
		LSS_ST_LSWAIT = 4'hb,
		LSS_ST_LINKUP = 4'hc
	} lss_state_t;

endpackage : lss_pkg

// *** lss_sync.sv ***
// three-stage synchroniser, a change passes once stages two and three agree
module lss_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] s1_q, s2_q, s3_q, q_q;
	logic [W-1:0] q_d;

	if (W < 1) begin : g_bad_w
		$error("lss_sync: W must be at least 1");
	end

	always_comb begin
		for (int i = 0; i < W; i++) begin
			q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q_q[i];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			q_q  <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q_q  <= q_d;
		end
	end

	assign q = q_q;

endmodule : lss_sync

// *** lss_device_model.sv ***
// device side model: management confirms and echoed link symbols
module lss_device_model
	import lss_pkg::*;
#(
	parameter int NUM_LANES = 2
) (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst,
	// scenario control
	input  wire logic [2:0]                dly,
	input  wire logic [NUM_LANES-1:0]      wired,
	input  wire logic                      lead,
	input  wire lss_caps_t                 caps,
	// host side
	input  wire lss_mgmt_req_t             mgmt_req,
	input  wire lss_lane_t [NUM_LANES-1:0] tx_lanes,
	output logic                           reset_cnf,
	output logic                           enable_cnf,
	output logic                           startup_cnf,
	output lss_lane_t [NUM_LANES-1:0]      rx_lanes
);
	lss_sym_t pipe_q [8];
	logic     on_q;

	always_ff @(posedge clk) begin
		if (rst || mgmt_req.reset_req) begin
			reset_cnf   <= !rst;
			enable_cnf  <= 1'b0;
			startup_cnf <= 1'b0;
			on_q        <= 1'b0;
			for (int i = 0; i < 8; i++) pipe_q[i] <= LSS_SYM_IDLE;
		end else begin
			if (mgmt_req.enable_req) begin
				reset_cnf  <= 1'b0;
				enable_cnf <= 1'b1;
				on_q       <= 1'b1;
			end
			if (mgmt_req.attr_restore) enable_cnf <= 1'b0;
			// echo keeps each phase symbol going
			// a leading device sends trigger zero before the host does
			pipe_q[0] <= !on_q ? LSS_SYM_IDLE :
				(lead && tx_lanes[0].sym == LSS_SYM_IDLE) ? LSS_SYM_TRG0 : tx_lanes[0].sym;
			for (int i = 1; i < 8; i++) pipe_q[i] <= pipe_q[i-1];
			if (on_q && pipe_q[dly] == LSS_SYM_CAP) startup_cnf <= 1'b1;
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_LANES; i++) begin
			rx_lanes[i] = wired[i] ? lss_lane_t'{pipe_q[dly], caps} : '0;
		end
	end
endmodule : lss_device_model

// *** lss_link_startup_sequencer_checker.sv ***
// protocol checker for the link startup sequencer
module lss_link_startup_sequencer_checker
	import lss_pkg::*;
#(
	parameter int NUM_LANES = 2
) (
	// clock and reset
	input wire logic                      clk,
	input wire logic                      rst,
	// control
	input wire logic                      start,
	// management requests and link lanes
	input wire lss_mgmt_req_t             mgmt_req,
	input wire lss_lane_t [NUM_LANES-1:0] tx_lanes,
	// status
	input wire logic                      mc_cap_start,
	input wire logic                      busy,
	input wire logic                      linkup,
	input wire logic [2:0]                power_mode,
	input wire logic [3:0]                gear
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence cap_entry;
		tx_lanes[0].sym == LSS_SYM_CAP && $past(tx_lanes[0].sym) == LSS_SYM_TRG2;
	endsequence

	gear_fixed_a: assert property (gear == 4'h1)
		else $error("gear is not one");
	req_single_a: assert property ($onehot0(mgmt_req))
		else $error("two requests at once");
	req_pulse_a: assert property (mgmt_req.reset_req |=> !mgmt_req.reset_req)
		else $error("reset request longer than a cycle");
	attr_start_a: assert property (mgmt_req.attr_restore |=> mgmt_req.startup_req)
		else $error("startup request does not follow restore");
	start_trg0_a: assert property (mgmt_req.startup_req |-> ##[0:1] tx_lanes[0].sym == LSS_SYM_TRG0)
		else $error("no trigger zero after startup");
	lanes_equal_a: assert property (tx_lanes[0] == tx_lanes[NUM_LANES-1])
		else $error("lanes differ");
	link_mode_a: assert property (linkup |-> power_mode == 3'h5 && !busy)
		else $error("linked without slow automatic mode");
	// the start pulse leads the first capability symbol by one cycle
	cap_start_a: assert property (mc_cap_start |=> cap_entry)
		else $error("converter start off phase five entry");
	cap_pulse_a: assert property (mc_cap_start |=> !mc_cap_start)
		else $error("converter start longer than a cycle");
	two_trg2_a: assert property (cap_entry |-> $past(tx_lanes[0].sym, 3) == LSS_SYM_TRG2)
		else $error("too few trigger two symbols");
	restart_a: assert property (start && linkup |=> mgmt_req.reset_req)
		else $error("restart without reset request");
endmodule : lss_link_startup_sequencer_checker

bind lss_link_startup_sequencer lss_link_startup_sequencer_checker #(.NUM_LANES(NUM_LANES)) u_chk (
	.clk, .rst, .start, .mgmt_req, .tx_lanes, .mc_cap_start, .busy, .linkup, .power_mode, .gear);

// *** tb_link_startup_sequencer.sv ***
// testbench of the link startup sequencer
module tb_link_startup_sequencer
	import lss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic                 clk, rst, start, hib, rcnf, ecnf, scnf, mcs, busy, linkup, lead;
	logic [2:0]           dly, pm;
	logic [1:0]           wired, mask;
	logic [3:0]           gear;
	lss_caps_t            own, pc, peer, agreed;
	lss_mgmt_req_t        req;
	lss_lane_t [1:0]      rx, tx;
	int                   fails = 0;
	int                   compares = 0;

	lss_link_startup_sequencer dut (.clk, .rst, .start, .own_caps(own), .phy_hibernate(hib),
		.mgmt_reset_cnf(rcnf), .mgmt_enable_cnf(ecnf), .link_startup_cnf(scnf), .mgmt_req(req),
		.rx_lanes(rx), .tx_lanes(tx), .mc_cap_start(mcs), .busy, .linkup, .power_mode(pm),
		.gear, .lane_mask(mask), .peer_caps(peer), .agreed_caps(agreed));
	lss_device_model u_dev (.clk, .rst, .dly, .wired, .lead, .caps(pc), .mgmt_req(req),
		.tx_lanes(tx), .reset_cnf(rcnf), .enable_cnf(ecnf), .startup_cnf(scnf), .rx_lanes(rx));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [3:0] mn(input logic [3:0] a, input logic [3:0] b);
		return (a < b) ? a : b;
	endfunction : mn

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		if (fails == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_no_hib();
		start = 1'b1;
		repeat (8) @(negedge clk);
		start = 1'b0;
		check("busy", busy, 1'b0);
		check("req", req, 4'h0);
		check("tx", tx[0].sym, LSS_SYM_IDLE);
	endtask : t_no_hib

	task automatic run_link(input logic [2:0] d, input logic [1:0] w, input logic l,
		input lss_caps_t c);
		int n;
		int pulses;
		pulses = 0;
		dly = d;
		wired = w;
		lead = l;
		pc = c;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		repeat (3) @(negedge clk);
		check("linkup_cleared", linkup, 1'b0);
		for (n = 0; n < 600 && linkup !== 1'b1; n++) begin
			@(negedge clk);
			pulses += int'(mcs === 1'b1);
		end
		check("linkup", linkup, 1'b1);
		check("power_mode", pm, 3'h5);
		check("gear", gear, 4'h1);
		check("busy", busy, 1'b0);
		check("lane_mask", mask, w);
		check("mc_cap_start", pulses, 32'h1);
		check("peer", peer, c);
		check("agreed", agreed, {mn(own.max_gear, c.max_gear),
			mn(mn(own.lane_cnt, c.lane_cnt), 4'(w[0]) + 4'(w[1]))});
	endtask : run_link

	task automatic t_stall();
		wired = 2'h0;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		repeat (200) @(negedge clk);
		check("stall_sym", tx[1].sym, LSS_SYM_TRG0);
		check("stall_busy", busy, 1'b1);
	endtask : t_stall

	// reset in mid-sequence, then a start before the hibernate status is through
	task automatic t_reset();
		rst = 1'b1;
		repeat (3) @(negedge clk);
		check("rst_out", {busy, linkup, mcs, pm, mask, req}, 12'h000);
		check("rst_gear", gear, 4'h1);
		check("rst_tx", tx, 22'h0);
		rst = 1'b0;
		start = 1'b1;
		repeat (2) @(negedge clk);
		start = 1'b0;
		check("early_busy", busy, 1'b0);
		check("early_req", req, 4'h0);
	endtask : t_reset

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		#400000;
		fails++;
		print_verdict();
	end

	initial begin
		rst = 1'b1;
		start = 1'b0;
		hib = 1'b0;
		dly = 3'h0;
		wired = 2'h3;
		lead = 1'b0;
		own = '{4'h3, 4'h2};
		pc = own;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		t_no_hib();
		hib = 1'b1;
		repeat (6) @(negedge clk);
		run_link(3'h0, 2'h3, 1'b0, '{4'h1, 4'h4});
		run_link(3'h7, 2'h1, 1'b1, '{4'h4, 4'h3});
		t_stall();
		t_reset();
		print_verdict();
	end
endmodule : tb_link_startup_sequencer
